// >>> verilog/irq_group_router_map.vh
// Group and line assignment constants for the interrupt request router.
// Assumes inclusion by bare name from the router design files.
`ifndef IRQ_GROUP_ROUTER_MAP_VH
`define IRQ_GROUP_ROUTER_MAP_VH
`define GROUP_COUNT 64
`define GROUP_INDEX_WIDTH 6
`define LINE_COUNT 32
`define LINE_INDEX_WIDTH 5
`define USED_GROUPS 20
`define GRP_CORE 6'h00
`define GRP_EXTPIN 6'h01
`define GRP_PORTPIN 6'h02
`define GRP_DMA 6'h03
`define GRP_FLASH 6'h04
`define GRP_UART0 6'h05
`define GRP_UART1 6'h06
`define GRP_UART2 6'h07
`define GRP_UART3 6'h08
`define GRP_SPI0 6'h09
`define GRP_SPI1 6'h0A
`define GRP_TWOWIRE 6'h0B
`define GRP_PWM 6'h0C
`define GRP_SYNCSER 6'h0D
`define GRP_TIMER 6'h0E
`define GRP_ADC 6'h0F
`define GRP_ETH 6'h10
`define GRP_USB 6'h11
`define GRP_SDRAM 6'h12
`define GRP_AUDIO 6'h13
`define EXTPIN_LINES 8
`define EXTPIN_RTC_LINE 5'h08
`define EXTPIN_POWER_LINE 5'h09
`define EXTPIN_FREQ_LINE 5'h0A
`define PORTPIN_LINES 14
`define DMA_LINES 15
`define TIMER_LINES 3
`endif

// >>> verilog/irq_group_reg.v
// One registered group of request lines with its any-line summary.
// Assumes its inputs are synchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
`include "irq_group_router_map.vh"
module irq_group_reg (
  input wire sys_clk,
  input wire arst_n,
  input wire [`LINE_COUNT-1:0] lines_in,
  output reg [`LINE_COUNT-1:0] lines_out,
  output reg group_active
);
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lines_out <= 32'h00000000;
      group_active <= 1'b0;
    end else begin
      lines_out <= lines_in;
      // One common request per group; lines are not ranked here.
      group_active <= |lines_in;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/irq_group_router.v
// Router from module interrupt request lines to the grouped controller inputs.
// Assumes all requests are level signals on sys_clk from on-chip logic.
// Functional notes
// - Up to 64 groups, six-bit group index.
// - Each group holds up to 32 lines.
// - Group lines share one vector and priority.
// - Every request wired by fixed group/line map.
// - Core cycle compare drives group 0 line 0.
// - PWM request drives group 12 line 0.
// - ADC request drives group 15 line 0.
// - USB OTG request drives group 17 line 0.
// - Audio converter request drives group 19 line 0.
`timescale 1ns/10ps
`default_nettype none
`include "irq_group_router_map.vh"
module irq_group_router (
  input wire sys_clk,
  input wire arst_n,
  input wire core_cycle_compare_irq,
  input wire [`EXTPIN_LINES-1:0] external_pin_irq_unit,
  input wire rtc_irq,
  input wire power_manager_irq,
  input wire frequency_meter_irq,
  input wire [`PORTPIN_LINES-1:0] port_pin_irq,
  input wire [`DMA_LINES-1:0] peripheral_dma_channel_irq,
  input wire flash_control_irq,
  input wire [3:0] uart_irq,
  input wire [1:0] spi_irq,
  input wire two_wire_irq,
  input wire pwm_irq,
  input wire sync_serial_irq,
  input wire [`TIMER_LINES-1:0] timer_irq,
  input wire adc_irq,
  input wire ethernet_mac_irq,
  input wire usb_otg_irq,
  input wire sdram_control_irq,
  input wire audio_dac_irq,
  output wire [`GROUP_COUNT*`LINE_COUNT-1:0] irq_group_controller_lines,
  output wire [`GROUP_COUNT-1:0] irq_group_controller_active
);
  // Flattened map: group g occupies bits [g*32 +: 32].
  reg [`GROUP_COUNT*`LINE_COUNT-1:0] routed;

  function [`GROUP_COUNT*`LINE_COUNT-1:0] place;
    input [`GROUP_COUNT*`LINE_COUNT-1:0] acc;
    input [`GROUP_INDEX_WIDTH-1:0] grp;
    input [`LINE_INDEX_WIDTH-1:0] line;
    input bit_val;
    reg [`GROUP_COUNT*`LINE_COUNT-1:0] tmp;
    begin
      tmp = acc;
      tmp[grp*`LINE_COUNT + line] = bit_val;
      place = tmp;
    end
  endfunction

  integer i;
  always @* begin
    // Start from all zero so unused positions never request.
    routed = {(`GROUP_COUNT*`LINE_COUNT){1'b0}};
    routed = place(routed, `GRP_CORE, 5'h00, core_cycle_compare_irq);
    for (i = 0; i < `EXTPIN_LINES; i = i + 1) begin
      routed = place(routed, `GRP_EXTPIN, i[4:0], external_pin_irq_unit[i]);
    end
    routed = place(routed, `GRP_EXTPIN, `EXTPIN_RTC_LINE, rtc_irq);
    routed = place(routed, `GRP_EXTPIN, `EXTPIN_POWER_LINE, power_manager_irq);
    routed = place(routed, `GRP_EXTPIN, `EXTPIN_FREQ_LINE, frequency_meter_irq);
    for (i = 0; i < `PORTPIN_LINES; i = i + 1) begin
      routed = place(routed, `GRP_PORTPIN, i[4:0], port_pin_irq[i]);
    end
    for (i = 0; i < `DMA_LINES; i = i + 1) begin
      routed = place(routed, `GRP_DMA, i[4:0], peripheral_dma_channel_irq[i]);
    end
    routed = place(routed, `GRP_FLASH, 5'h00, flash_control_irq);
    routed = place(routed, `GRP_UART0, 5'h00, uart_irq[0]);
    routed = place(routed, `GRP_UART1, 5'h00, uart_irq[1]);
    routed = place(routed, `GRP_UART2, 5'h00, uart_irq[2]);
    routed = place(routed, `GRP_UART3, 5'h00, uart_irq[3]);
    routed = place(routed, `GRP_SPI0, 5'h00, spi_irq[0]);
    routed = place(routed, `GRP_SPI1, 5'h00, spi_irq[1]);
    routed = place(routed, `GRP_TWOWIRE, 5'h00, two_wire_irq);
    routed = place(routed, `GRP_PWM, 5'h00, pwm_irq);
    routed = place(routed, `GRP_SYNCSER, 5'h00, sync_serial_irq);
    for (i = 0; i < `TIMER_LINES; i = i + 1) begin
      routed = place(routed, `GRP_TIMER, i[4:0], timer_irq[i]);
    end
    routed = place(routed, `GRP_ADC, 5'h00, adc_irq);
    routed = place(routed, `GRP_ETH, 5'h00, ethernet_mac_irq);
    routed = place(routed, `GRP_USB, 5'h00, usb_otg_irq);
    routed = place(routed, `GRP_SDRAM, 5'h00, sdram_control_irq);
    routed = place(routed, `GRP_AUDIO, 5'h00, audio_dac_irq);
  end

  // Registering each of the 20 used groups costs one cycle of latency but gives the
  // controller clean, glitch-free levels from a single flop stage.
  genvar g;
  generate
    for (g = 0; g < `USED_GROUPS; g = g + 1) begin : grp
      irq_group_reg u_reg (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .lines_in(routed[g*`LINE_COUNT +: `LINE_COUNT]),
        .lines_out(irq_group_controller_lines[g*`LINE_COUNT +: `LINE_COUNT]),
        .group_active(irq_group_controller_active[g])
      );
    end
  endgenerate

  // Groups with no source are held inactive.
  assign irq_group_controller_lines[`GROUP_COUNT*`LINE_COUNT-1:`USED_GROUPS*`LINE_COUNT] =
    {((`GROUP_COUNT-`USED_GROUPS)*`LINE_COUNT){1'b0}};
  assign irq_group_controller_active[`GROUP_COUNT-1:`USED_GROUPS] =
    {(`GROUP_COUNT-`USED_GROUPS){1'b0}};
endmodule
`default_nettype wire

// >>> verif/irq_group_router_monitor.sv
// Checker on the request router ports.
// Assumes it is bound into every router instance.
`timescale 1ns/10ps
`default_nettype none
module irq_group_router_chk (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic core_cycle_compare_irq,
  input wire logic pwm_irq,
  input wire logic adc_irq,
  input wire logic usb_otg_irq,
  input wire logic audio_dac_irq,
  input wire logic [2047:0] irq_group_controller_lines,
  input wire logic [63:0] irq_group_controller_active
);
  // The release edge still loads the reset value, so the core, PWM, PWM group and audio lag checks also need the
  // reset to have been high when their attempt was sampled.
  logic [63:0] any_line;
  always_comb for (int g = 0; g < 64; g++) any_line[g] = |irq_group_controller_lines[g*32 +: 32];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  core_line_a: assert property (arst_n && core_cycle_compare_irq |=> irq_group_controller_lines[0])
    else $error("core line");
  pwm_line_a: assert property (arst_n |=> irq_group_controller_lines[384] == $past(pwm_irq))
    else $error("pwm line");
  adc_line_a: assert property (!adc_irq |=> !irq_group_controller_lines[480])
    else $error("adc line");
  usb_line_a: assert property ($rose(usb_otg_irq) |=> irq_group_controller_lines[544])
    else $error("usb line");
  audio_line_a: assert property (arst_n |=> irq_group_controller_lines[608] == $past(audio_dac_irq))
    else $error("audio line");
  high_groups_a: assert property (irq_group_controller_lines[2047:640] == 0)
    else $error("high groups");
  group_or_a: assert property (irq_group_controller_active == any_line)
    else $error("group summary");
  pwm_group_a: assert property (arst_n && pwm_irq |=> irq_group_controller_active[12])
    else $error("pwm group");
endmodule
bind irq_group_router irq_group_router_chk chk (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .core_cycle_compare_irq(core_cycle_compare_irq),
  .pwm_irq(pwm_irq),
  .adc_irq(adc_irq),
  .usb_otg_irq(usb_otg_irq),
  .audio_dac_irq(audio_dac_irq),
  .irq_group_controller_lines(irq_group_controller_lines),
  .irq_group_controller_active(irq_group_controller_active)
);
`default_nettype wire

// >>> verif/irq_source_model.sv
// Request source model: raises one request, all of them, or none.
// Assumes sel changes just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module irq_source_model (
  input wire logic [6:0] sel,
  output logic [58:0] req
);
  // Sources hold levels for whole cycles.
  assign req = (sel == 7'h7F) ? {59{1'b1}} : (sel < 7'h3B) ? (59'h1 << sel) : 59'h0;
endmodule
`default_nettype wire

// >>> verif/irq_group_router_tb.sv
// Testbench walking every request input through the router.
// Assumes the source model and bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module irq_group_router_tb;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [6:0] sel = 7'h7E;
  wire [58:0] r;
  wire [2047:0] lines;
  wire [63:0] active;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  irq_source_model src (.sel(sel), .req(r));
  irq_group_router dut (.sys_clk(sys_clk), .arst_n(arst_n), .core_cycle_compare_irq(r[0]),
    .external_pin_irq_unit(r[8:1]), .rtc_irq(r[9]), .power_manager_irq(r[10]),
    .frequency_meter_irq(r[11]), .port_pin_irq(r[25:12]), .peripheral_dma_channel_irq(r[40:26]),
    .flash_control_irq(r[41]), .uart_irq(r[45:42]), .spi_irq(r[47:46]), .two_wire_irq(r[48]),
    .pwm_irq(r[49]), .sync_serial_irq(r[50]), .timer_irq(r[53:51]), .adc_irq(r[54]),
    .ethernet_mac_irq(r[55]), .usb_otg_irq(r[56]), .sdram_control_irq(r[57]),
    .audio_dac_irq(r[58]), .irq_group_controller_lines(lines),
    .irq_group_controller_active(active));
  function automatic int pos(input int i);
    if (i == 0) return 0;
    if (i < 12) return i + 31;
    if (i < 26) return i + 52;
    if (i < 41) return i + 70;
    if (i < 51) return 32 * i - 1184;
    if (i < 54) return i + 397;
    return 32 * i - 1248;
  endfunction
  task automatic check_out(input logic [2047:0] el, input logic [63:0] ea);
    checks_done++;
    if (lines !== el || active !== ea) begin
      errors++;
      $display("[ERR] %0t output mismatch", $time);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Back-to-back one-hot walk; each output is checked the cycle after its input.
  task automatic walk_map();
    for (int i = 0; i <= 59; i++) begin
      @(posedge sys_clk) sel <= (i < 59) ? 7'(i) : 7'h7E;
      #1;
      if (i > 0) check_out(2048'h1 << pos(i - 1), 64'h1 << (pos(i - 1) / 32));
    end
  endtask
  task automatic all_on();
    logic [2047:0] el;
    el = 2048'h0;
    for (int k = 0; k < 59; k++) el[pos(k)] = 1'b1;
    @(posedge sys_clk) sel <= 7'h7F;
    @(posedge sys_clk) #1 check_out(el, 64'h0000_0000_000F_FFFF);
    @(posedge sys_clk) arst_n <= 1'b0;
    #1 check_out(2048'h0, 64'h0);
    // Requests stay up through the release: the release edge must still show zero.
    @(posedge sys_clk) arst_n <= 1'b1;
    #1 check_out(2048'h0, 64'h0);
    @(posedge sys_clk) sel <= 7'h7E;
    #1 check_out(el, 64'h0000_0000_000F_FFFF);
    repeat (2) @(posedge sys_clk);
    #1 check_out(2048'h0, 64'h0);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 check_out(2048'h0, 64'h0);
    @(posedge sys_clk) arst_n <= 1'b1;
    walk_map();
    all_on();
    tally_and_finish();
  end
endmodule
`default_nettype wire
